/* File: design/rfd_params.svh */
`ifndef RFD_PARAMS_SVH
`define RFD_PARAMS_SVH

// System clock rate.
`define RFD_CLK_HZ          100000000
// Crystal and master reference rates in hertz.
`define RFD_XTAL_HZ         2450000
`define RFD_MASTER_HZ       19200
// Crystal edges per half period of the master square wave, nearest whole count.
`define RFD_XTAL_HALF_DIV   ((`RFD_XTAL_HZ + `RFD_MASTER_HZ) / (2 * `RFD_MASTER_HZ))
`define RFD_XDIV_W          7
// Twisted-ring stage counts: a ring of N stages divides by 2N.
`define RFD_DIV_4K8_STAGES  2
`define RFD_DIV_1K92_STAGES 5
`define RFD_DIV_1K6_STAGES  6
`define RFD_CYC_STAGES      6
`define RFD_CYC_STATES      12
// Master periods per 400 Hz period, and the missed-edge timeout.
`define RFD_MASTER_PER_CYC  48
`define RFD_LOSS_PERIODS    96
`define RFD_CHANNELS        2

`endif

/* File: design/rfd_pkg.sv */
package rfd_pkg;

   typedef enum logic {
      RFD_SEL_A,
      RFD_SEL_B
   } rfd_sel_t;

   typedef enum logic [0:0] {
      RFD_CH_A,
      RFD_CH_B
   } rfd_chan_t;

endpackage

/* File: design/rfd_sel_if.sv */
interface rfd_sel_if;
   logic             watch_rise;
   logic             master_tick;
   rfd_pkg::rfd_sel_t sel;

   modport mon (
      input  watch_rise,
      input  master_tick,
      output sel
   );

   modport top (
      output watch_rise,
      output master_tick,
      input  sel
   );
endinterface

/* File: design/rfd_johnson.sv */
`include "rfd_params.svh"

module rfd_johnson #(
   parameter int W = 2
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_tick,
   output logic [W-1:0]      o_state,
   output logic              o_rise
);

   logic [W-1:0] state_q;

   // Each tick shifts up and feeds back the inverted top stage, so every stage is a
   // clean half-duty square wave at 1/(2W) of the tick rate with no decode gates.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_q <= '0;
      end else if (i_tick) begin
         state_q <= {state_q[W-2:0], ~state_q[W-1]};
      end
   end

   assign o_state = state_q;
   // The top stage rises on the tick that moves a one into it.
   assign o_rise  = i_tick & state_q[W-2] & ~state_q[W-1];

   function automatic logic ring_ok(input logic [W-1:0] v);
      logic [W-1:0] d;
      d = (v ^ (v >> 1)) & {1'b0, {(W-1){1'b1}}};
      return ($countones(d) <= 1);
   endfunction

   property p_ring_legal;
      @(posedge i_clk) disable iff (i_sys_rst)
         ring_ok(state_q);
   endproperty
   a_ring_legal: assert property (p_ring_legal)
      else $error("Twisted-ring counter left its legal code set.");

   property p_step_only_on_tick;
      @(posedge i_clk) disable iff (i_sys_rst)
         !i_tick |=> $stable(state_q);
   endproperty
   a_step_only_on_tick: assert property (p_step_only_on_tick)
      else $error("Twisted-ring counter moved without a tick.");

endmodule

/* File: design/rfd_loss_mon.sv */
`include "rfd_params.svh"

module rfd_loss_mon #(
   parameter int LOSS_PERIODS = `RFD_LOSS_PERIODS
) (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   rfd_sel_if.mon    bus
);

   localparam int CW = $clog2(LOSS_PERIODS + 1);
   localparam logic [CW-1:0] LAST = CW'(LOSS_PERIODS - 1);

   logic [CW-1:0]     cnt_q;
   rfd_pkg::rfd_sel_t sel_q;
   logic              timeout;

   // The count runs on the backup master, so a dead channel A oscillator still times out.
   assign timeout = bus.master_tick && (cnt_q == LAST);

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
      end else if (bus.watch_rise) begin
         cnt_q <= '0;
      end else if (bus.master_tick && cnt_q != LAST) begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   // Once on channel B the selection latches until reset; a recovered A is not trusted.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         sel_q <= rfd_pkg::RFD_SEL_A;
      end else begin
         case (sel_q)
            rfd_pkg::RFD_SEL_A: begin
               if (timeout) begin
                  sel_q <= rfd_pkg::RFD_SEL_B;
               end
            end
            rfd_pkg::RFD_SEL_B: sel_q <= rfd_pkg::RFD_SEL_B;
            default: sel_q <= rfd_pkg::RFD_SEL_B;
         endcase
      end
   end

   assign bus.sel = sel_q;

   property p_timeout_switches;
      @(posedge i_clk) disable iff (i_sys_rst)
         timeout |=> (sel_q == rfd_pkg::RFD_SEL_B);
   endproperty
   a_timeout_switches: assert property (p_timeout_switches)
      else $error("Selector did not move to channel B on timeout.");

   property p_sel_holds;
      @(posedge i_clk) disable iff (i_sys_rst)
         (sel_q == rfd_pkg::RFD_SEL_B) |=> (sel_q == rfd_pkg::RFD_SEL_B);
   endproperty
   a_sel_holds: assert property (p_sel_holds)
      else $error("Selector left channel B before reset.");

   property p_edge_clears;
      @(posedge i_clk) disable iff (i_sys_rst)
         bus.watch_rise |=> (cnt_q == '0);
   endproperty
   a_edge_clears: assert property (p_edge_clears)
      else $error("Watched edge did not restart the loss timer.");

   property p_no_early_switch;
      @(posedge i_clk) disable iff (i_sys_rst)
         (sel_q == rfd_pkg::RFD_SEL_A) && !timeout |=> (sel_q == rfd_pkg::RFD_SEL_A);
   endproperty
   a_no_early_switch: assert property (p_no_early_switch)
      else $error("Selector switched without a timeout.");

   c_switch: cover property (@(posedge i_clk) disable iff (i_sys_rst) timeout);

endmodule

/* File: design/rfd_top.sv */
// Operation
// - Master 19.2 kHz square wave is divided down from the 2.45 MHz crystal.
// - Master feeds two separately divided 4.8 kHz square waves.
// - One 4.8 kHz wave clocks the cycle register, the other feeds the amplifier.
// - Auxiliary dividers give 4.8, 1.92 and 1.6 kHz reference square waves.
// - All dividers after the master are twisted-ring counters; outputs come straight from stages.
// - Six complementary 400 Hz outputs, each lagging the previous by 30 degrees.
// - Six cycle register flip-flops change only on the 4.8 kHz clock pulse.
// - Each cycle register stage drives one amplifier channel, true and complement.
// - Oscillator divider, dividers and cycle register exist twice, both running.
// - Missing 400 Hz on channel A switches the load to B and holds it.
`include "rfd_params.svh"

module rfd_top #(
   parameter int LOSS_PERIODS = `RFD_LOSS_PERIODS,
   parameter int XTAL_HALF    = `RFD_XTAL_HALF_DIV
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_sys_rst,
   input  wire logic                       i_xtal_a,
   input  wire logic                       i_xtal_b,
   output logic [`RFD_CYC_STAGES-1:0]      o_phase,
   output logic [`RFD_CYC_STAGES-1:0]      o_phase_n,
   output logic                            o_amp_4k8,
   output logic                            o_ref_4k8,
   output logic                            o_ref_1k92,
   output logic                            o_ref_1k6,
   output logic                            o_on_chan_b
);

   localparam int NCH = `RFD_CHANNELS;
   localparam int CS  = `RFD_CYC_STAGES;
   localparam logic [`RFD_XDIV_W-1:0] XDIV_LAST = `RFD_XDIV_W'(XTAL_HALF - 1);

   logic [NCH-1:0]           xtal_pin;
   logic [NCH-1:0]           xs1_q;
   logic [NCH-1:0]           xs2_q;
   logic [NCH-1:0]           xs3_q;
   logic [NCH-1:0]           xrise;
   logic [`RFD_XDIV_W-1:0]   xdiv_q [NCH];
   logic [NCH-1:0]           master_q;
   logic [NCH-1:0]           master_tick;

   logic [NCH-1:0]           cyc_clk_sq;
   logic [NCH-1:0]           cyc_tick;
   logic [NCH-1:0]           amp_sq;
   logic [NCH-1:0]           ref48_sq;
   logic [NCH-1:0]           ref192_sq;
   logic [NCH-1:0]           ref16_sq;
   logic [CS-1:0]            cyc_st [NCH];
   logic [NCH-1:0]           cyc_rise;

   logic [CS-1:0]            phase_q;
   logic [CS-1:0]            phase_n_q;
   logic                     amp_q;
   logic                     ref48_q;
   logic                     ref192_q;
   logic                     ref16_q;
   logic                     on_b_q;
   logic                     use_b;

   rfd_sel_if sel_bus ();

   assign xtal_pin = {i_xtal_b, i_xtal_a};

   // Crystal pins are asynchronous; two flops settle them before the edge detector.
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         xs1_q <= '0;
         xs2_q <= '0;
         xs3_q <= '0;
      end else begin
         xs1_q <= xtal_pin;
         xs2_q <= xs1_q;
         xs3_q <= xs2_q;
      end
   end

   assign xrise = xs2_q & ~xs3_q;

   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      logic [`RFD_DIV_4K8_STAGES-1:0]  cyc_div_st;
      logic [`RFD_DIV_4K8_STAGES-1:0]  amp_div_st;
      logic [`RFD_DIV_4K8_STAGES-1:0]  r48_st;
      logic [`RFD_DIV_1K92_STAGES-1:0] r192_st;
      logic [`RFD_DIV_1K6_STAGES-1:0]  r16_st;

      // Master square wave: toggle after a fixed count of crystal edges.
      always_ff @(posedge i_clk) begin
         if (i_sys_rst) begin
            xdiv_q[ch]   <= '0;
            master_q[ch] <= 1'b0;
         end else if (xrise[ch]) begin
            if (xdiv_q[ch] == XDIV_LAST) begin
               xdiv_q[ch]   <= '0;
               master_q[ch] <= ~master_q[ch];
            end else begin
               xdiv_q[ch] <= xdiv_q[ch] + `RFD_XDIV_W'(1);
            end
         end
      end

      // Every divider below steps on the master's rising edge only.
      assign master_tick[ch] = xrise[ch] && (xdiv_q[ch] == XDIV_LAST) && !master_q[ch];

      // Two independent 4.8 kHz dividers, one per load.
      rfd_johnson #(.W(`RFD_DIV_4K8_STAGES)) u_cyc_div (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_tick    (master_tick[ch]),
         .o_state   (cyc_div_st),
         .o_rise    (cyc_tick[ch])
      );

      rfd_johnson #(.W(`RFD_DIV_4K8_STAGES)) u_amp_div (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_tick    (master_tick[ch]),
         .o_state   (amp_div_st),
         .o_rise    ()
      );

      rfd_johnson #(.W(`RFD_DIV_4K8_STAGES)) u_ref48 (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_tick    (master_tick[ch]),
         .o_state   (r48_st),
         .o_rise    ()
      );

      rfd_johnson #(.W(`RFD_DIV_1K92_STAGES)) u_ref192 (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_tick    (master_tick[ch]),
         .o_state   (r192_st),
         .o_rise    ()
      );

      rfd_johnson #(.W(`RFD_DIV_1K6_STAGES)) u_ref16 (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_tick    (master_tick[ch]),
         .o_state   (r16_st),
         .o_rise    ()
      );

      // Cycle register: six stages, twelve states, one 4.8 kHz period per state.
      rfd_johnson #(.W(CS)) u_cycle (
         .i_clk     (i_clk),
         .i_sys_rst (i_sys_rst),
         .i_tick    (cyc_tick[ch]),
         .o_state   (cyc_st[ch]),
         .o_rise    (cyc_rise[ch])
      );

      assign cyc_clk_sq[ch] = cyc_div_st[`RFD_DIV_4K8_STAGES-1];
      assign amp_sq[ch]     = amp_div_st[`RFD_DIV_4K8_STAGES-1];
      assign ref48_sq[ch]   = r48_st[`RFD_DIV_4K8_STAGES-1];
      assign ref192_sq[ch]  = r192_st[`RFD_DIV_1K92_STAGES-1];
      assign ref16_sq[ch]   = r16_st[`RFD_DIV_1K6_STAGES-1];
   end

   // The top stage of channel A's cycle register is the watched 400 Hz output.
   assign sel_bus.watch_rise  = cyc_rise[rfd_pkg::RFD_CH_A];
   assign sel_bus.master_tick = master_tick[rfd_pkg::RFD_CH_B];

   rfd_loss_mon #(.LOSS_PERIODS(LOSS_PERIODS)) u_loss (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .bus       (sel_bus.mon)
   );

   // Both channels keep running; only the output multiplexer follows the selector.
   assign use_b = (sel_bus.sel == rfd_pkg::RFD_SEL_B);

   // Channel select for the single-bit reference outputs; both channels run regardless.
   function automatic logic pick(input logic [NCH-1:0] v, input logic b);
      return b ? v[1] : v[0];
   endfunction

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         phase_q   <= '0;
         phase_n_q <= '1;
      end else begin
         phase_q   <= use_b ? cyc_st[1] : cyc_st[0];
         phase_n_q <= use_b ? ~cyc_st[1] : ~cyc_st[0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         amp_q    <= 1'b0;
         ref48_q  <= 1'b0;
         ref192_q <= 1'b0;
         ref16_q  <= 1'b0;
      end else begin
         amp_q    <= pick(amp_sq, use_b);
         ref48_q  <= pick(ref48_sq, use_b);
         ref192_q <= pick(ref192_sq, use_b);
         ref16_q  <= pick(ref16_sq, use_b);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         on_b_q <= 1'b0;
      end else begin
         on_b_q <= use_b;
      end
   end

   assign o_phase     = phase_q;
   assign o_phase_n   = phase_n_q;
   assign o_amp_4k8   = amp_q;
   assign o_ref_4k8   = ref48_q;
   assign o_ref_1k92  = ref192_q;
   assign o_ref_1k6   = ref16_q;
   assign o_on_chan_b = on_b_q;

   property p_master_on_xtal;
      @(posedge i_clk) disable iff (i_sys_rst)
         $changed(master_q[0]) |-> $past(xrise[0]);
   endproperty
   a_master_on_xtal: assert property (p_master_on_xtal)
      else $error("Master wave moved without a crystal edge.");

   property p_two_4k8_lockstep;
      @(posedge i_clk) disable iff (i_sys_rst)
         cyc_clk_sq[0] == amp_sq[0];
   endproperty
   a_two_4k8_lockstep: assert property (p_two_4k8_lockstep)
      else $error("The two 4.8 kHz dividers disagree.");

   property p_cycle_clock_source;
      @(posedge i_clk) disable iff (i_sys_rst)
         $rose(cyc_clk_sq[0]) |-> $past(cyc_tick[0]);
   endproperty
   a_cycle_clock_source: assert property (p_cycle_clock_source)
      else $error("Cycle register stepped off its 4.8 kHz edge.");

   property p_ref_follows;
      @(posedge i_clk) disable iff (i_sys_rst)
         !use_b ##1 !use_b |-> o_ref_1k6 == $past(ref16_sq[0]);
   endproperty
   a_ref_follows: assert property (p_ref_follows)
      else $error("1.6 kHz reference does not follow channel A.");

   property p_complement;
      @(posedge i_clk) disable iff (i_sys_rst)
         o_phase_n == ~o_phase;
   endproperty
   a_complement: assert property (p_complement)
      else $error("Phase outputs are not complementary.");

   property p_lag_30;
      @(posedge i_clk) disable iff (i_sys_rst)
         cyc_tick[0] |=> cyc_st[0][CS-1:1] == $past(cyc_st[0][CS-2:0]);
   endproperty
   a_lag_30: assert property (p_lag_30)
      else $error("Cycle register stage did not take its neighbour's value.");

   property p_wrap;
      @(posedge i_clk) disable iff (i_sys_rst)
         cyc_tick[0] && cyc_st[0] == 6'h3F |=> cyc_st[0] == 6'h3E;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("Cycle register ring did not invert its feedback.");

   property p_b_lockstep;
      @(posedge i_clk) disable iff (i_sys_rst)
         cyc_clk_sq[1] == amp_sq[1];
   endproperty
   a_b_lockstep: assert property (p_b_lockstep)
      else $error("Channel B 4.8 kHz dividers disagree.");

   property p_b_lag_30;
      @(posedge i_clk) disable iff (i_sys_rst)
         cyc_tick[1] |=> cyc_st[1][CS-1:1] == $past(cyc_st[1][CS-2:0]);
   endproperty
   a_b_lag_30: assert property (p_b_lag_30)
      else $error("Channel B cycle register stage did not take its neighbour's value.");

   property p_drive_one;
      @(posedge i_clk) disable iff (i_sys_rst)
         use_b |=> o_phase == $past(cyc_st[1]);
   endproperty
   a_drive_one: assert property (p_drive_one)
      else $error("Phase output does not follow the selected channel.");

   property p_flag_tracks;
      @(posedge i_clk) disable iff (i_sys_rst)
         use_b |=> o_on_chan_b ##1 o_on_chan_b;
   endproperty
   a_flag_tracks: assert property (p_flag_tracks)
      else $error("Channel B flag dropped after the switch.");

   c_master_a: cover property (@(posedge i_clk) disable iff (i_sys_rst) master_tick[0]);
   c_cycle_b: cover property (@(posedge i_clk) disable iff (i_sys_rst) cyc_rise[1]);
   c_on_b: cover property (@(posedge i_clk) disable iff (i_sys_rst) $rose(o_on_chan_b));
   c_full_ring: cover property (@(posedge i_clk) disable iff (i_sys_rst)
      cyc_tick[0] && cyc_st[0] == 6'h20);

endmodule

/* File: test/rfd_amp_model.sv */
`include "rfd_params.svh"

// Six push-pull amplifier channels; each conducts on one half of its primary.
module rfd_amp_model (
   input  wire logic                       i_clk,
   input  wire logic [`RFD_CYC_STAGES-1:0] i_drive,
   input  wire logic [`RFD_CYC_STAGES-1:0] i_drive_n,
   output int                              o_faults,
   output logic [`RFD_CYC_STAGES-1:0]      o_winding
);
   timeunit 1ns;
   timeprecision 1ps;

   initial o_faults = 0;
   assign o_winding = i_drive & ~i_drive_n;

   // Both halves on or both off would short or starve a transformer.
   always @(negedge i_clk) begin
      if (i_drive_n !== ~i_drive) begin
         o_faults++;
      end
   end
endmodule

/* File: test/rfd_top_tb.sv */
`include "rfd_params.svh"

module rfd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int XH   = 2;
   localparam int LOSS = 60;

   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_xtal_a = 1'b0;
   logic i_xtal_b = 1'b0;
   logic [5:0] o_phase;
   logic [5:0] o_phase_n;
   logic o_amp_4k8, o_ref_4k8, o_ref_1k92, o_ref_1k6, o_on_chan_b;
   logic [9:0] sv, prev_sv;
   logic [5:0] prev_ph;
   logic en_a = 1'b1;
   logic en_b = 1'b1;
   logic chk_ring = 1'b0;
   int hp = 4;
   int ca, cb, cyc, wd, faults;
   int rise_t[10], per[10], hi[10];
   int err_total = 0;
   int comparisons = 0;
   int dv[10] = '{48, 48, 48, 48, 48, 48, 4, 4, 10, 12};

   initial begin
      forever #5 i_clk = ~i_clk;
   end

   rfd_top #(.LOSS_PERIODS(LOSS), .XTAL_HALF(XH)) dut (
      .i_clk      (i_clk),
      .i_sys_rst  (i_sys_rst),
      .i_xtal_a   (i_xtal_a),
      .i_xtal_b   (i_xtal_b),
      .o_phase    (o_phase),
      .o_phase_n  (o_phase_n),
      .o_amp_4k8  (o_amp_4k8),
      .o_ref_4k8  (o_ref_4k8),
      .o_ref_1k92 (o_ref_1k92),
      .o_ref_1k6  (o_ref_1k6),
      .o_on_chan_b(o_on_chan_b)
   );

   rfd_amp_model amp (
      .i_clk    (i_clk),
      .i_drive  (o_phase),
      .i_drive_n(o_phase_n),
      .o_faults (faults),
      .o_winding()
   );

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk_vec(input logic [5:0] got, input logic [5:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_num(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp) begin
         err_total++;
         $display("CHECK FAILED %0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   // Crystal edges are made on the falling clock edge, away from the sampling edge.
   always @(negedge i_clk) begin
      if (en_a) begin
         ca <= (ca >= hp - 1) ? 0 : ca + 1;
         if (ca >= hp - 1) i_xtal_a <= ~i_xtal_a;
      end
      if (en_b) begin
         cb <= (cb >= hp - 1) ? 0 : cb + 1;
         if (cb >= hp - 1) i_xtal_b <= ~i_xtal_b;
      end
   end

   assign sv = {o_ref_1k6, o_ref_1k92, o_ref_4k8, o_amp_4k8, o_phase};

   always @(negedge i_clk) begin
      cyc++;
      for (int i = 0; i < 10; i++) begin
         if (sv[i] === 1'b1 && prev_sv[i] === 1'b0) begin
            per[i] = cyc - rise_t[i];
            rise_t[i] = cyc;
         end
         if (sv[i] === 1'b0 && prev_sv[i] === 1'b1) hi[i] = cyc - rise_t[i];
      end
      if (chk_ring && !i_sys_rst && o_phase !== prev_ph) begin
         chk_vec(o_phase, {prev_ph[4:0], ~prev_ph[5]}, "ring step");
      end
      prev_sv = sv;
      prev_ph = o_phase;
   end

   // Ceiling well above the at most roughly 40500 cycles the sequence needs.
   always @(posedge i_clk) begin
      wd++;
      if (wd == 90000) begin
         err_total++;
         $display("CHECK FAILED %0t run did not finish", $time);
         conclude();
      end
   end

   function automatic int master_per(input int h);
      return 2 * XH * 2 * h;
   endfunction

   task automatic do_reset();
      @(negedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(negedge i_clk);
      chk_vec(o_phase, 6'h00, "reset phase");
      chk_vec(o_phase_n, 6'h3F, "reset phase_n");
      chk_vec({1'b0, o_amp_4k8, o_ref_4k8, o_ref_1k92, o_ref_1k6, o_on_chan_b}, 6'h00, "reset");
      i_sys_rst <= 1'b0;
      @(negedge i_clk);
      chk_vec(o_phase, 6'h00, "phase after release");
   endtask

   task automatic settle();
      repeat (3 * 48 * master_per(hp)) @(negedge i_clk);
   endtask

   task automatic check_rates();
      int pm;
      pm = master_per(hp);
      for (int i = 0; i < 10; i++) begin
         chk_num(per[i], dv[i] * pm, "period");
         chk_num(hi[i], dv[i] * pm / 2, "high time");
      end
   endtask

   task automatic check_lag();
      int pm, r0, t;
      pm = master_per(hp);
      r0 = rise_t[5];
      t = 0;
      while (rise_t[5] == r0 && t < 50 * pm) begin
         @(negedge i_clk);
         t++;
      end
      for (int k = 1; k < 6; k++) begin
         chk_num(rise_t[k] - rise_t[k - 1], 4 * pm, "phase lag");
      end
   endtask

   initial begin
      int t, pm;
      void'($urandom(52140));
      ca <= $urandom % 3;
      cb <= $urandom % 3;
      repeat (2) @(negedge i_clk);
      i_sys_rst <= 1'b0;
      do_reset();
      chk_ring <= 1'b1;
      for (int r = 0; r < 3; r++) begin
         hp = (r == 0) ? 3 : 3 + $urandom % 4;
         settle();
         check_rates();
         check_lag();
         chk_bit(o_on_chan_b, 1'b0, "stays on A");
      end
      // Kill crystal A; a jump in phase is legal at the moment of the switch.
      pm = master_per(hp);
      chk_ring <= 1'b0;
      en_a <= 1'b0;
      t = 0;
      while (o_on_chan_b !== 1'b1 && t < LOSS * pm + 200) begin
         @(negedge i_clk);
         t++;
      end
      chk_bit(o_on_chan_b, 1'b1, "switch to B");
      // The kill lands a few cycles after a channel A ring edge, so the full timeout must run.
      chk_bit(t >= (LOSS - 2) * pm, 1'b1, "switch not early");
      chk_bit(t <= LOSS * pm + 20, 1'b1, "switch at once");
      repeat (4) @(negedge i_clk);
      chk_ring <= 1'b1;
      en_a <= 1'b1;
      settle();
      chk_bit(o_on_chan_b, 1'b1, "B held");
      check_rates();
      check_lag();
      do_reset();
      en_b <= 1'b0;
      repeat (LOSS * pm + 48 * pm) @(negedge i_clk);
      chk_bit(o_on_chan_b, 1'b0, "B dead, A kept");
      check_rates();
      chk_num(faults, 0, "push-pull faults");
      conclude();
   end
endmodule
